/* File: dspfc_top.sv */
// Decided for this implementation: the register offsets and the strobed register port.
`default_nettype none
// What this block does
// - Each port keeps own baud, length
// - Exactly one controlling port, handover by command
// - Commands both ports, hex stream computer only
// - Start bit then eight data bits
// - Stop bit count set per port
// - Parity sent and checked per port
// - Request-to-send high while not paused and below pause level
// - Start transmit only while clear-to-send high
// - Clear-to-send absent means transmit allowed
// - Resume DC1, pause DC3 by default
// - Pause when nearly full, resume when empty
// - Computer receive buffer holds 64 characters
// - Pause sent at eight buffered characters
// - Request-to-send follows pause and resume
module dspfc_top #(
  parameter int RX_DEPTH = 64,
  parameter int XOFF_LVL = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [dspfc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dspfc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dspfc_pkg::DATA_W-1:0] o_rdata,
  // Serial lines, bit 0 terminal, bit 1 computer
  input wire logic [dspfc_pkg::NPORT-1:0] i_rxd,
  output logic [dspfc_pkg::NPORT-1:0] o_txd,
  output logic [dspfc_pkg::NPORT-1:0] o_rts,
  input wire logic [dspfc_pkg::NPORT-1:0] i_cts,
  // Controlling port
  output logic o_owner
);
  import dspfc_pkg::*;
  localparam int PW = $clog2(RX_DEPTH);
  localparam logic [PW:0] LVL = (PW + 1)'(XOFF_LVL);
  localparam logic [PW:0] FULLC = (PW + 1)'(RX_DEPTH);

  if (RX_DEPTH < 2 || (1 << PW) != RX_DEPTH || XOFF_LVL < 1
      || XOFF_LVL >= RX_DEPTH) begin : g_bad_param
    $error("dspfc_top: buffer depth or pause level not usable");
  end

  logic owner, next_owner;
  logic [CHAR_W-1:0] xon_chr, next_xon_chr;
  logic [CHAR_W-1:0] xoff_chr, next_xoff_chr;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic [DATA_W-1:0] cfg_v [NPORT];
  logic [DATA_W-1:0] stat_v [NPORT];
  logic [CHAR_W-1:0] head_v [NPORT];

  // Shared control registers
  always_comb begin
    next_owner = owner;
    next_xon_chr = xon_chr;
    next_xoff_chr = xoff_chr;
    // single owner bit, toggled on handover
    if (i_wr && i_addr == A_CTRL && i_wdata[C_HANDOVER]) begin
      next_owner = ~owner;
    end
    if (i_wr && i_addr == A_XCHR) begin
      next_xon_chr = i_wdata[F_XON +: CHAR_W];
      next_xoff_chr = i_wdata[F_XOFF +: CHAR_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      owner <= 1'b0;
      xon_chr <= XON_DEF;
      xoff_chr <= XOFF_DEF;
    end else begin
      owner <= next_owner;
      xon_chr <= next_xon_chr;
      xoff_chr <= next_xoff_chr;
    end
  end

  assign o_owner = owner;

  // Read path, data valid the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      if (i_addr == A_CTRL) begin
        next_rdata = DATA_W'(owner) << C_OWNER;
      end else if (i_addr == A_XCHR) begin
        next_rdata = (DATA_W'(xoff_chr) << F_XOFF) | (DATA_W'(xon_chr) << F_XON);
      end
      for (int p = 0; p < NPORT; p++) begin
        if (i_addr == port_base(p) + O_CFG) begin
          next_rdata = cfg_v[p];
        end
        if (i_addr == port_base(p) + O_DATA) begin
          next_rdata = DATA_W'(head_v[p]);
        end
        if (i_addr == port_base(p) + O_STAT) begin
          next_rdata = stat_v[p];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam logic [ADDR_W-1:0] BASE = port_base(p);
    dspfc_ser_if sif ();
    logic [DATA_W-1:0] cfg, next_cfg;
    logic hold_full, next_hold_full;
    logic [CHAR_W-1:0] hold_byte, next_hold_byte;
    logic [CHAR_W-1:0] mem [RX_DEPTH];
    logic [PW-1:0] wp, next_wp, rp, next_rp;
    logic [PW:0] cnt, next_cnt;
    logic paused, next_paused;
    logic held, next_held;
    logic perr, next_perr, ferr, next_ferr, ovr, next_ovr;
    logic rts, next_rts, go, next_go;
    logic [CHAR_W-1:0] go_byte, next_go_byte;
    logic wr_cfg, wr_dat, rd_dat, rd_stat;
    logic push, pop, is_xon, is_xoff, flow_chr, cts_ok, tx_free;

    always_comb begin
      wr_cfg = i_wr && i_addr == BASE + O_CFG;
      // stream register feeds computer port only
      wr_dat = i_wr && (i_addr == BASE + O_DATA
               || (p == PORT_COMP && i_addr == A_STREAM));
      rd_dat = i_rd && i_addr == BASE + O_DATA;
      rd_stat = i_rd && i_addr == BASE + O_STAT;
      is_xon = cfg[F_SWFC] && sif.rx_byte == xon_chr;
      is_xoff = cfg[F_SWFC] && sif.rx_byte == xoff_chr;
      flow_chr = is_xon || is_xoff;
      // ignore the pin when told it is absent
      cts_ok = i_cts[p] || cfg[F_CTS_OFF];
      tx_free = !go && !sif.tx_busy && cts_ok;
      pop = rd_dat && cnt != '0;
      push = sif.rx_stb && !flow_chr && (cnt != FULLC || pop);

      next_cfg = wr_cfg ? (i_wdata & CFG_MASK) : cfg;
      next_wp = push ? wp + 1'b1 : wp;
      next_rp = pop ? rp + 1'b1 : rp;
      next_cnt = cnt;
      if (push && !pop) begin
        next_cnt = cnt + 1'b1;
      end else if (pop && !push) begin
        next_cnt = cnt - 1'b1;
      end

      // Sticky errors; a new error beats the read clear
      next_perr = (perr && !rd_stat) || (sif.rx_stb && sif.rx_perr);
      next_ferr = (ferr && !rd_stat) || (sif.rx_stb && sif.rx_ferr);
      next_ovr = (ovr && !rd_stat) || (sif.rx_stb && !flow_chr && !push);

      // Far end pausing us
      next_held = held;
      if (sif.rx_stb && is_xoff) begin
        next_held = 1'b1;
      end else if (sif.rx_stb && is_xon) begin
        next_held = 1'b0;
      end
      if (!cfg[F_SWFC]) begin
        next_held = 1'b0;
      end

      next_hold_full = hold_full;
      next_hold_byte = hold_byte;
      if (wr_dat && !hold_full) begin
        next_hold_full = 1'b1;
        next_hold_byte = i_wdata[CHAR_W-1:0];
      end

      // Flow characters go ahead of data
      next_go = 1'b0;
      next_go_byte = go_byte;
      next_paused = paused;
      if (!cfg[F_SWFC]) begin
        if (!paused && cnt >= LVL) begin
          next_paused = 1'b1;
        end else if (paused && cnt == '0) begin
          next_paused = 1'b0;
        end
      end
      if (tx_free) begin
        // pause at once when nearly full
        if (cfg[F_SWFC] && !paused && cnt >= LVL) begin
          next_go = 1'b1;
          next_go_byte = xoff_chr;
          next_paused = 1'b1;
        end else if (cfg[F_SWFC] && paused && cnt == '0) begin
          next_go = 1'b1;
          next_go_byte = xon_chr;
          next_paused = 1'b0;
        end else if (hold_full && !held) begin
          next_go = 1'b1;
          next_go_byte = hold_byte;
          next_hold_full = 1'b0;
        end
      end

      next_rts = !(next_paused || next_cnt >= LVL);
    end

    always_ff @(posedge i_clk) begin
      if (push) begin
        mem[wp] <= sif.rx_byte;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        cfg <= CFG_RST;
        hold_full <= 1'b0;
        hold_byte <= '0;
        wp <= '0;
        rp <= '0;
        cnt <= '0;
        paused <= 1'b0;
        held <= 1'b0;
        perr <= 1'b0;
        ferr <= 1'b0;
        ovr <= 1'b0;
        rts <= 1'b1;
        go <= 1'b0;
        go_byte <= '0;
      end else begin
        cfg <= next_cfg;
        hold_full <= next_hold_full;
        hold_byte <= next_hold_byte;
        wp <= next_wp;
        rp <= next_rp;
        cnt <= next_cnt;
        paused <= next_paused;
        held <= next_held;
        perr <= next_perr;
        ferr <= next_ferr;
        ovr <= next_ovr;
        rts <= next_rts;
        go <= next_go;
        go_byte <= next_go_byte;
      end
    end

    assign sif.div = cfg[F_DIV +: DIV_W];
    assign sif.stop2 = cfg[F_STOP2];
    assign sif.par = cfg[F_PAR +: 2];
    assign sif.seven = cfg[F_SEVEN];
    assign sif.tx_go = go;
    assign sif.tx_byte = go_byte;

    dspfc_serdes u_ser (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .s(sif),
      .i_rxd(i_rxd[p]),
      .o_txd(o_txd[p])
    );

    assign o_rts[p] = rts;
    assign cfg_v[p] = cfg;
    assign head_v[p] = mem[rp];
    assign stat_v[p] = (DATA_W'(cnt) << S_CNT)
                     | (DATA_W'(hold_full) << S_TXFULL)
                     | (DATA_W'(sif.tx_busy) << S_TXBUSY)
                     | (DATA_W'(perr) << S_PERR)
                     | (DATA_W'(ferr) << S_FERR)
                     | (DATA_W'(ovr) << S_OVR)
                     | (DATA_W'(rts) << S_RTS)
                     | (DATA_W'(i_cts[p]) << S_CTS)
                     | (DATA_W'(paused) << S_PAUSED)
                     | (DATA_W'(held) << S_HELD)
                     | (DATA_W'(owner == 1'(p)) << S_OWNER);
  end
endmodule
`default_nettype wire

/* File: dspfc_pkg.sv */
`default_nettype none
package dspfc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NPORT = 2;
  localparam int PORT_TERM = 0;
  localparam int PORT_COMP = 1;
  localparam int CHAR_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Register map
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_XCHR = 8'h04;
  localparam logic [ADDR_W-1:0] A_STREAM = 8'h08;
  localparam logic [ADDR_W-1:0] A_PORT_T = 8'h10;
  localparam logic [ADDR_W-1:0] A_PORT_C = 8'h20;
  localparam logic [ADDR_W-1:0] O_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] O_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] O_STAT = 8'h08;
  // Control and flow character fields
  localparam int C_OWNER = 0;
  localparam int C_HANDOVER = 1;
  localparam int F_XON = 0;
  localparam int F_XOFF = 8;
  localparam logic [CHAR_W-1:0] XON_DEF = 8'h11;
  localparam logic [CHAR_W-1:0] XOFF_DEF = 8'h13;
  // Port setting fields
  localparam int F_DIV = 0;
  localparam int DIV_W = 16;
  localparam int F_STOP2 = 16;
  localparam int F_PAR = 17;
  localparam int F_SEVEN = 19;
  localparam int F_SWFC = 20;
  localparam int F_CTS_OFF = 21;
  localparam logic [DATA_W-1:0] CFG_MASK = 32'h003F_FFFF;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEF = 9600;
  localparam logic [DIV_W-1:0] DIV_DEF = DIV_W'(CLK_HZ / BAUD_DEF);
  localparam logic [DATA_W-1:0] CFG_RST = (32'h1 << F_SWFC) | DATA_W'(DIV_DEF);
  // Status fields
  localparam int S_CNT = 0;
  localparam int S_TXFULL = 8;
  localparam int S_TXBUSY = 9;
  localparam int S_PERR = 10;
  localparam int S_FERR = 11;
  localparam int S_OVR = 12;
  localparam int S_RTS = 13;
  localparam int S_CTS = 14;
  localparam int S_PAUSED = 15;
  localparam int S_HELD = 16;
  localparam int S_OWNER = 17;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  typedef enum logic [2:0] {
    SER_IDLE = 3'h0,
    SER_START = 3'h1,
    SER_DATA = 3'h3,
    SER_PAR = 3'h2,
    SER_STOP = 3'h6
  } dspfc_ser_type;

  function automatic logic par_bit(input logic [CHAR_W-1:0] d, input logic [1:0] m);
    return (m == PAR_ODD) ? ~^d : ^d;
  endfunction

  function automatic logic has_par(input logic [1:0] m);
    return (m == PAR_EVEN) || (m == PAR_ODD);
  endfunction

  function automatic logic [ADDR_W-1:0] port_base(input int p);
    return (p == PORT_COMP) ? A_PORT_C : A_PORT_T;
  endfunction
endpackage
`default_nettype wire

/* File: dspfc_ser_if.sv */
`default_nettype none
interface dspfc_ser_if;
  logic [dspfc_pkg::DIV_W-1:0] div;
  logic stop2;
  logic [1:0] par;
  logic seven;
  logic tx_go;
  logic [dspfc_pkg::CHAR_W-1:0] tx_byte;
  logic tx_busy;
  logic rx_stb;
  logic [dspfc_pkg::CHAR_W-1:0] rx_byte;
  logic rx_perr;
  logic rx_ferr;
  modport ctl(output div, stop2, par, seven, tx_go, tx_byte,
              input tx_busy, rx_stb, rx_byte, rx_perr, rx_ferr);
  modport eng(input div, stop2, par, seven, tx_go, tx_byte,
              output tx_busy, rx_stb, rx_byte, rx_perr, rx_ferr);
endinterface
`default_nettype wire

/* File: dspfc_serdes.sv */
`default_nettype none
module dspfc_serdes (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Settings and characters
  dspfc_ser_if.eng s,
  // Line
  input wire logic i_rxd,
  output logic o_txd
);
  import dspfc_pkg::*;
  localparam logic [DIV_W-1:0] ONE = DIV_W'(1);
  dspfc_ser_type t_st, next_t_st, r_st, next_r_st;
  logic [DIV_W-1:0] t_cnt, next_t_cnt, r_cnt, next_r_cnt;
  logic [2:0] t_bit, next_t_bit, r_bit, next_r_bit;
  logic [CHAR_W-1:0] t_sh, next_t_sh, r_sh, next_r_sh;
  logic t_stop, next_t_stop, txd, next_txd;
  logic stb, next_stb, perr, next_perr, ferr, next_ferr;
  logic t_tick, r_tick;

  always_comb begin
    t_tick = (t_cnt == '0);
    next_t_st = t_st;
    next_t_cnt = t_cnt;
    next_t_bit = t_bit;
    next_t_sh = t_sh;
    next_t_stop = t_stop;
    next_txd = txd;
    if (t_st != SER_IDLE) begin
      next_t_cnt = t_tick ? s.div - ONE : t_cnt - ONE;
    end
    case (t_st)
      // start bit, then eight data bits
      SER_IDLE: if (s.tx_go) begin
        next_t_st = SER_START;
        next_t_cnt = s.div - ONE;
        next_t_bit = '0;
        next_t_sh = s.seven ? {1'b0, s.tx_byte[CHAR_W-2:0]} : s.tx_byte;
        next_txd = 1'b0;
      end
      SER_START: if (t_tick) begin
        next_t_st = SER_DATA;
        next_txd = t_sh[0];
      end
      SER_DATA: if (t_tick) begin
        next_t_bit = t_bit + 1'b1;
        next_txd = t_sh[t_bit + 1'b1];
        if (t_bit == BIT_LAST) begin
          if (has_par(s.par)) begin
            next_t_st = SER_PAR;
            next_txd = par_bit(t_sh, s.par);
          end else begin
            next_t_st = SER_STOP;
            next_txd = 1'b1;
            next_t_stop = s.stop2;
          end
        end
      end
      SER_PAR: if (t_tick) begin
        next_t_st = SER_STOP;
        next_txd = 1'b1;
        next_t_stop = s.stop2;
      end
      SER_STOP: if (t_tick) begin
        if (t_stop) begin
          next_t_stop = 1'b0;
        end else begin
          next_t_st = SER_IDLE;
        end
      end
      default: begin
        next_t_st = SER_IDLE;
        next_txd = 1'b1;
      end
    endcase
  end

  always_comb begin
    r_tick = (r_cnt == '0);
    next_r_st = r_st;
    next_r_cnt = r_cnt;
    next_r_bit = r_bit;
    next_r_sh = r_sh;
    next_stb = 1'b0;
    next_perr = perr;
    next_ferr = ferr;
    if (r_st != SER_IDLE) begin
      next_r_cnt = r_tick ? s.div - ONE : r_cnt - ONE;
    end
    case (r_st)
      // Half a bit to land mid-cell; one less for the detect cycle
      SER_IDLE: if (!i_rxd) begin
        next_r_st = SER_START;
        next_r_cnt = (s.div >> 1) - ONE;
      end
      SER_START: if (r_tick) begin
        next_r_st = i_rxd ? SER_IDLE : SER_DATA;
        next_r_bit = '0;
        next_perr = 1'b0;
      end
      SER_DATA: if (r_tick) begin
        next_r_sh[r_bit] = i_rxd;
        next_r_bit = r_bit + 1'b1;
        if (r_bit == BIT_LAST) begin
          next_r_st = has_par(s.par) ? SER_PAR : SER_STOP;
        end
      end
      SER_PAR: if (r_tick) begin
        next_perr = (i_rxd != par_bit(r_sh, s.par));
        next_r_st = SER_STOP;
      end
      SER_STOP: if (r_tick) begin
        next_stb = 1'b1;
        next_ferr = !i_rxd;
        next_r_st = SER_IDLE;
      end
      default: next_r_st = SER_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      t_st <= SER_IDLE;
      t_cnt <= '0;
      t_bit <= '0;
      t_sh <= '0;
      t_stop <= 1'b0;
      txd <= 1'b1;
      r_st <= SER_IDLE;
      r_cnt <= '0;
      r_bit <= '0;
      r_sh <= '0;
      stb <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else begin
      t_st <= next_t_st;
      t_cnt <= next_t_cnt;
      t_bit <= next_t_bit;
      t_sh <= next_t_sh;
      t_stop <= next_t_stop;
      txd <= next_txd;
      r_st <= next_r_st;
      r_cnt <= next_r_cnt;
      r_bit <= next_r_bit;
      r_sh <= next_r_sh;
      stb <= next_stb;
      perr <= next_perr;
      ferr <= next_ferr;
    end
  end

  assign o_txd = txd;
  assign s.tx_busy = (t_st != SER_IDLE);
  assign s.rx_stb = stb;
  assign s.rx_byte = s.seven ? {1'b0, r_sh[CHAR_W-2:0]} : r_sh;
  assign s.rx_perr = perr;
  assign s.rx_ferr = ferr;
endmodule
`default_nettype wire

/* File: dspfc_monitor.sv */
`default_nettype none
module dspfc_monitor
  import dspfc_pkg::*;
#(
  parameter int RX_DEPTH = 64,
  parameter int XOFF_LVL = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [dspfc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dspfc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [dspfc_pkg::DATA_W-1:0] o_rdata,
  // Serial lines
  input wire logic [dspfc_pkg::NPORT-1:0] i_rxd,
  input wire logic [dspfc_pkg::NPORT-1:0] o_txd,
  input wire logic [dspfc_pkg::NPORT-1:0] o_rts,
  input wire logic [dspfc_pkg::NPORT-1:0] i_cts,
  // Controlling port
  input wire logic o_owner
);
  logic rts_c;
  logic cts_c;
  logic txd_c;
  logic [6:0] hi_cnt;
  logic [6:0] next_hi_cnt;
  logic cts_off;
  logic next_cts_off;
  assign rts_c = o_rts[1];
  assign cts_c = i_cts[1];
  assign txd_c = o_txd[1];
  // Idle only judged for small divisors, a frame is shorter than 64 clocks
  always_comb begin
    next_hi_cnt = txd_c ? ((hi_cnt == 7'h7F) ? hi_cnt : hi_cnt + 7'h01) : 7'h00;
    next_cts_off = cts_off;
    if (i_wr && i_addr == A_PORT_C + O_CFG) begin
      next_cts_off = i_wdata[F_CTS_OFF];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hi_cnt <= 7'h00;
      cts_off <= 1'b0;
    end else begin
      hi_cnt <= next_hi_cnt;
      cts_off <= next_cts_off;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero outside read answer");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) >= 8'h2C |-> o_rdata == '0)
    else $error("unmapped read not zero");
  owner_read_a: assert property ($past(i_rd) && $past(i_addr) == A_CTRL |-> o_rdata[0] == $past(o_owner))
    else $error("control read disagrees with owner");
  owner_flip_a: assert property (i_wr && i_addr == A_CTRL && i_wdata[C_HANDOVER] |=> o_owner != $past(o_owner))
    else $error("handover did not move control");
  owner_keep_a: assert property (!(i_wr && i_addr == A_CTRL && i_wdata[C_HANDOVER]) |=> $stable(o_owner))
    else $error("owner changed without handover");
  stat_flags_a: assert property ($past(i_rd) && $past(i_addr) == A_PORT_C + O_STAT
    |-> o_rdata[S_RTS] == $past(rts_c) && o_rdata[S_OWNER] == $past(o_owner))
    else $error("status flags disagree with pins");
  reset_idle_a: assert property (disable iff (1'b0) i_rst
    |=> o_txd == 2'h3 && o_rts == 2'h3 && !o_owner && o_rdata == '0)
    else $error("outputs not idle after reset");
  cts_block_a: assert property (txd_c && hi_cnt >= 7'h40 && !cts_off && !cts_c && !$past(cts_c)
    && !$past(cts_c, 2) && !$past(cts_c, 3) |=> txd_c)
    else $error("transmit started with clear-to-send low");
  rts_back_a: assert property ($rose(rts_c) |-> ($past(i_rd) && $past(i_addr) == A_PORT_C + O_DATA)
    || ($past(i_rd, 2) && $past(i_addr, 2) == A_PORT_C + O_DATA)
    || ($past(i_rd, 3) && $past(i_addr, 3) == A_PORT_C + O_DATA))
    else $error("request-to-send rose without a drain");
  cover property ($fell(rts_c));
  cover property (i_wr && i_addr == A_CTRL && i_wdata[C_HANDOVER]);
  cover property ($fell(txd_c) && hi_cnt >= 7'h40);
endmodule
bind dspfc_top dspfc_monitor #(.RX_DEPTH(RX_DEPTH), .XOFF_LVL(XOFF_LVL)) mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd), .o_rts(o_rts),
  .i_cts(i_cts), .o_owner(o_owner));
`default_nettype wire

/* File: dspfc_host.sv */
`default_nettype none
module dspfc_host (
  // Clock
  input wire logic i_clk,
  // Lines
  input wire logic i_txd,
  output var logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 4;
  bit par_en = 1'b0;
  bit par_odd = 1'b0;
  bit bad_par = 1'b0;
  int perr = 0;
  int ferr = 0;
  logic [7:0] rx_q[$];
  initial o_rxd = 1'b1;
  // start, low bit first, flow codes kept as data
  always begin : rx_frame
    logic [7:0] d;
    @(negedge i_txd);
    repeat (div / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge i_clk);
      d[i] = i_txd;
    end
    if (par_en) begin
      repeat (div) @(posedge i_clk);
      if (i_txd !== (^d ^ par_odd)) perr++;
    end
    repeat (div) @(posedge i_clk);
    if (i_txd !== 1'b1) ferr++;
    rx_q.push_back(d);
  end
  // one frame, line back at mark
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = par_en ? {1'b1, ^c ^ par_odd ^ bad_par, c} : {2'b11, c};
    @(posedge i_clk);
    o_rxd <= 1'b0;
    repeat (div) @(posedge i_clk);
    for (int i = 0; i < (par_en ? 10 : 9); i++) begin
      o_rxd <= f[i];
      repeat (div) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb_dual_serial_port_flow_control.sv */
`default_nettype none
module tb_dual_serial_port_flow_control;
  timeunit 1ns;
  timeprecision 1ns;
  import dspfc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_cts = 2'h3;
  wire logic [1:0] rxd;
  logic [DATA_W-1:0] o_rdata;
  logic [1:0] o_txd;
  logic [1:0] o_rts;
  logic o_owner;
  logic [31:0] v;
  int error_cnt = 0;
  int total_checks = 0;
  always #50 i_clk = ~i_clk;
  dspfc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd),
    .o_rts(o_rts), .i_cts(i_cts), .o_owner(o_owner));
  dspfc_host host_t (.i_clk(i_clk), .i_txd(o_txd[0]), .o_rxd(rxd[0]));
  dspfc_host host_c (.i_clk(i_clk), .i_txd(o_txd[1]), .o_rxd(rxd[1]));
  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_q(input int p, input int n);
    int k;
    for (k = 0; k < 20000; k++) begin
      if ((p == 0 ? host_t.rx_q.size() : host_c.rx_q.size()) >= n) break;
      @(posedge i_clk);
    end
    if (k == 20000) begin
      error_cnt++;
      $display("[ERR] line %0d expected %0d chars seen timeout", p, n);
      finish_test();
    end
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk("txd_rst", 32'h3, 32'(o_txd));
    chk("rts_rst", 32'h3, 32'(o_rts));
    rd(A_PORT_T + O_CFG, v);
    chk("cfg_t_rst", CFG_RST, v);
    rd(A_PORT_C + O_CFG, v);
    chk("cfg_c_rst", CFG_RST, v);
    rd(A_XCHR, v);
    chk("xchr_rst", {16'h0, XOFF_DEF, XON_DEF}, v);
    rd(8'hFC, v);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
    host_t.div = 4;
    host_c.div = 6;
    wr(A_PORT_T + O_CFG, 32'h0020_0004);
    wr(A_PORT_C + O_CFG, 32'h0010_0006);
    rd(A_PORT_T + O_CFG, v);
    chk("cfg_t", 32'h0020_0004, v);
    rd(A_PORT_C + O_CFG, v);
    chk("cfg_c", 32'h0010_0006, v);
    $display("test port settings done");
    // Every parity code; code 3 also with two stop bits
    for (int m = 0; m < 4; m++) begin
      host_t.par_en = (m == 1 || m == 2);
      host_t.par_odd = (m == 2);
      host_t.rx_q.delete();
      wr(A_PORT_T + O_CFG, 32'h0020_0004 | (32'(m) << F_PAR) | (32'(m == 3) << F_STOP2));
      wr(A_PORT_T + O_DATA, 32'hA5 ^ 32'(m));
      wait_q(0, 1);
      chk("tx_char", 32'hA5 ^ 32'(m), 32'(host_t.rx_q[0]));
      host_t.send(8'h3C + 8'(m));
      rd(A_PORT_T + O_DATA, v);
      chk("rx_char", 32'h3C + 32'(m), v);
    end
    chk("tx_perr", 32'h0, 32'(host_t.perr));
    chk("tx_ferr", 32'h0, 32'(host_t.ferr));
    host_t.par_en = 1'b1;
    host_t.par_odd = 1'b0;
    wr(A_PORT_T + O_CFG, 32'h0022_0004);
    host_t.bad_par = 1'b1;
    host_t.send(8'h66);
    host_t.bad_par = 1'b0;
    rd(A_PORT_T + O_STAT, v);
    chk("perr_set", 32'h1, 32'(v[S_PERR]));
    rd(A_PORT_T + O_STAT, v);
    chk("perr_clr", 32'h0, 32'(v[S_PERR]));
    rd(A_PORT_T + O_DATA, v);
    host_t.par_en = 1'b0;
    // Seven-bit mode masks the top bit both ways
    wr(A_PORT_T + O_CFG, 32'h0028_0004);
    host_t.rx_q.delete();
    wr(A_PORT_T + O_DATA, 32'hC3);
    wait_q(0, 1);
    chk("tx_seven", 32'h43, 32'(host_t.rx_q[0]));
    host_t.send(8'hC3);
    rd(A_PORT_T + O_DATA, v);
    chk("rx_seven", 32'h43, v);
    wr(A_PORT_T + O_CFG, 32'h0020_0004);
    $display("test framing done");
    i_cts <= 2'h0;
    host_t.rx_q.delete();
    host_c.rx_q.delete();
    wr(A_PORT_C + O_DATA, 32'h5A);
    wr(A_PORT_T + O_DATA, 32'h69);
    wait_q(0, 1);
    chk("cts_off_tx", 32'h69, 32'(host_t.rx_q[0]));
    repeat (200) @(posedge i_clk);
    chk("cts_low_hold", 32'h0, 32'(host_c.rx_q.size()));
    i_cts <= 2'h2;
    wait_q(1, 1);
    chk("cts_high_tx", 32'h5A, 32'(host_c.rx_q[0]));
    host_c.rx_q.delete();
    host_t.rx_q.delete();
    wr(A_STREAM, 32'h3A);
    wait_q(1, 1);
    repeat (60) @(posedge i_clk);
    chk("stream_c", 32'h3A, 32'(host_c.rx_q[0]));
    chk("stream_t", 32'h0, 32'(host_t.rx_q.size()));
    $display("test transmit gating done");
    chk("owner0", 32'h0, 32'(o_owner));
    wr(A_CTRL, 32'h2);
    chk("owner1", 32'h1, 32'(o_owner));
    rd(A_PORT_C + O_STAT, v);
    chk("stat_owner", 32'h1, 32'(v[S_OWNER]));
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, v);
    chk("ctrl_keep", 32'h1, v);
    wr(A_CTRL, 32'h2);
    chk("owner_back", 32'h0, 32'(o_owner));
    $display("test control done");
    host_c.rx_q.delete();
    for (int i = 0; i < 7; i++) host_c.send(8'h40 + 8'(i));
    chk("rts_seven", 32'h1, 32'(o_rts[1]));
    host_c.send(8'h47);
    chk("rts_eight", 32'h0, 32'(o_rts[1]));
    wait_q(1, 1);
    chk("pause_char", 32'(XOFF_DEF), 32'(host_c.rx_q[0]));
    rd(A_PORT_C + O_STAT, v);
    chk("count8", 32'h8, 32'(v[6:0]));
    chk("paused", 32'h1, 32'(v[S_PAUSED]));
    // sent on past the pause to fill and overrun the buffer
    for (int i = 8; i < 64; i++) host_c.send(8'h40 + 8'(i));
    host_c.send(8'h20);
    rd(A_PORT_C + O_STAT, v);
    chk("count64", 32'h40, 32'(v[6:0]));
    chk("overrun", 32'h1, 32'(v[S_OVR]));
    for (int i = 0; i < 64; i++) begin
      rd(A_PORT_C + O_DATA, v);
      chk("drain", 32'h40 + 32'(i), v);
    end
    wait_q(1, 2);
    chk("resume_char", 32'(XON_DEF), 32'(host_c.rx_q[1]));
    chk("rts_resume", 32'h1, 32'(o_rts[1]));
    // Far end pauses us, data must wait for its resume
    host_c.send(XOFF_DEF);
    wr(A_PORT_C + O_DATA, 32'h55);
    repeat (200) @(posedge i_clk);
    chk("held_tx", 32'h2, 32'(host_c.rx_q.size()));
    host_c.send(XON_DEF);
    wait_q(1, 3);
    chk("resume_tx", 32'h55, 32'(host_c.rx_q[2]));
    $display("test flow control done");
    finish_test();
  end
endmodule
`default_nettype wire
